// file: pkg/cgcb_pkg.sv
// constants for the clock generator control byte bank
package cgcb_pkg;
    // byte offsets
    localparam logic [7:0] CGCB_OFS_SEL_STOP = 8'h00;
    localparam logic [7:0] CGCB_OFS_HOST_EN  = 8'h01;
    // byte zero field positions
    localparam int CGCB_B0_SEL_A   = 0;
    localparam int CGCB_B0_SEL_B   = 1;
    localparam int CGCB_B0_SEL_C   = 2;
    localparam int CGCB_B0_PSTOP   = 3;
    localparam int CGCB_B0_HSTOP   = 4;
    localparam int CGCB_B0_VSEL    = 5;
    localparam int CGCB_B0_UNUSED  = 6;
    localparam int CGCB_B0_SPREAD  = 7;
    // byte one field positions
    localparam int CGCB_B1_EN0     = 0;
    localparam int CGCB_B1_FREE0   = 3;
    localparam int CGCB_B1_UNUSED  = 6;
    localparam int CGCB_B1_MULT    = 7;
    localparam int CGCB_NPAIR      = 3;
    // reset values
    localparam logic       CGCB_RST_PSTOP  = 1'b1;
    localparam logic       CGCB_RST_VSEL   = 1'b0;
    localparam logic       CGCB_RST_SPREAD = 1'b0;
    localparam logic [2:0] CGCB_RST_EN     = 3'h7;
    localparam logic [2:0] CGCB_RST_FREE   = 3'h0;
    // sequencer timing, 250 mhz clock
    localparam int CGCB_CLK_KHZ      = 250000;
    localparam int CGCB_STABLE_US    = 3000;
    // short delays keep power-up well inside the bound and a full bench run brief
    localparam int CGCB_PLL_DLY_US   = 10;
    localparam int CGCB_OUT_DLY_US   = 100;
    localparam int CGCB_PLL_DLY_CYC  = CGCB_PLL_DLY_US * (CGCB_CLK_KHZ / 1000);
    localparam int CGCB_OUT_DLY_CYC  = CGCB_OUT_DLY_US * (CGCB_CLK_KHZ / 1000);
    localparam int CGCB_STABLE_CYC   = CGCB_STABLE_US * (CGCB_CLK_KHZ / 1000);
    localparam int CGCB_CNT_W        = 20;
    typedef enum logic [1:0] {CGCB_WAIT, CGCB_PLL, CGCB_SETTLE, CGCB_RUN} cgcb_state_t;
endpackage : cgcb_pkg

// file: hw/cgcb_sync.sv
// two-flop synchroniser for a group of pin levels
`timescale 1ns/10ps
`default_nettype none
module cgcb_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         arst_n,
    // pins in, synced levels out
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    // first flop feeds only the second
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_q   <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q   <= pin_in;
            sync_out <= meta_q;
        end
    end
endmodule : cgcb_sync
`default_nettype wire

// file: hw/cgcb_regs.sv
// control byte bank and power-up sequencer of the clock generator
// Behaviour
// - byte0 bits 0-2 read the three frequency-select pins latched at power-up.
// - byte0 bit3 writable; readback and peripheral gating use bit AND stop pin.
// - byte0 bit4 reads the live host-clock stop pin.
// - byte0 bit5 picks 66 or 48 MHz on shared output; resets to 66.
// - byte1 bits 3-5 decide per pair whether the stop pin halts it.
// - stop gating bits reset to 0, so pairs obey the stop pin.
// - byte1 bit7 reads the multiplier-select pin latched at startup.
// - supply-sense event starts a timed sequence; first step latches pins.
// - latched pin levels set the mode and hold while powered.
// - one cycle after latch enable pll; after two further delays enable clock outputs.
// - outputs run within 3 ms of supply good.
`timescale 1ns/10ps
`default_nettype none
module cgcb_regs
    import cgcb_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    // supply sense and strap pins
    input  wire logic       supply_good,
    input  wire logic [2:0] freq_sel_pins,
    input  wire logic       mult_sel_pin,
    // stop pins
    input  wire logic       periph_stop_pin,
    input  wire logic       host_stop_pin,
    // byte access port
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    // sequencer state
    output logic            pll_enable,
    output logic            clocks_enable,
    output logic            mode_valid,
    // mode and gating outputs
    output logic      [2:0] freq_sel_mode,
    output logic            multiplier_select_snapshot,
    output logic            periph_clocks_run,
    output logic            video_clock_source_select,
    output logic            spread_enable,
    output logic      [2:0] host_pair_run
);
    logic [2:0]  sel_pins_s;
    logic        mult_s;
    logic        pstop_s;
    logic        hstop_s;
    logic        sgood_s;
    logic [2:0]  freq_sel_snapshot_q;
    logic        mult_q;
    logic        pstop_bit_q;
    logic        vsel_q;
    logic        spread_q;
    logic [2:0]  pair_en_q;
    logic [2:0]  pair_free_q;
    logic        latch_done_q;
    logic [CGCB_CNT_W-1:0] cnt_q;
    cgcb_state_t state_q;
    logic        pstop_eff;
    logic [7:0]  byte0;
    logic [7:0]  byte1;

    // synchronise all pin inputs, two flops each
    cgcb_sync #(.W(7)) u_sync (
        .clk      (clk),
        .arst_n   (arst_n),
        .pin_in   ({supply_good, host_stop_pin, periph_stop_pin, mult_sel_pin, freq_sel_pins}),
        .sync_out ({sgood_s, hstop_s, pstop_s, mult_s, sel_pins_s})
    );

    // power-up sequencer; delays are kept well inside the 3 ms stable bound
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_q <= CGCB_WAIT;
            cnt_q   <= '0;
        end
        else
        begin
            case (state_q)
                CGCB_WAIT:
                    if (sgood_s)
                    begin
                        state_q <= CGCB_PLL;
                        cnt_q   <= '0;
                    end
                CGCB_PLL:
                    if (cnt_q == CGCB_CNT_W'(CGCB_PLL_DLY_CYC - 1))
                    begin
                        state_q <= CGCB_SETTLE;
                        cnt_q   <= '0;
                    end
                    else
                        cnt_q <= cnt_q + 1'b1;
                CGCB_SETTLE:
                    if (cnt_q == CGCB_CNT_W'(CGCB_OUT_DLY_CYC - 1))
                        state_q <= CGCB_RUN;
                    else
                        cnt_q <= cnt_q + 1'b1;
                default:
                    state_q <= CGCB_RUN;                   // stays until power goes
            endcase
        end
    end

    // strap capture on the supply-sense event, held until reset
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            freq_sel_snapshot_q <= '0;
            mult_q              <= 1'b0;
            latch_done_q        <= 1'b0;
        end
        else if (state_q == CGCB_WAIT && sgood_s && !latch_done_q)
        begin
            freq_sel_snapshot_q <= sel_pins_s;
            mult_q              <= mult_s;
            latch_done_q        <= 1'b1;
        end
    end

    // writable control bits of byte zero
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pstop_bit_q <= CGCB_RST_PSTOP;
            vsel_q      <= CGCB_RST_VSEL;
            spread_q    <= CGCB_RST_SPREAD;
        end
        else if (reg_wr && reg_addr == CGCB_OFS_SEL_STOP)
        begin
            pstop_bit_q <= reg_wdata[CGCB_B0_PSTOP];
            vsel_q      <= reg_wdata[CGCB_B0_VSEL];
            spread_q    <= reg_wdata[CGCB_B0_SPREAD];
        end
    end

    // writable control bits of byte one; bit 6 and 7 are not stored
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pair_en_q   <= CGCB_RST_EN;
            pair_free_q <= CGCB_RST_FREE;
        end
        else if (reg_wr && reg_addr == CGCB_OFS_HOST_EN)
        begin
            pair_en_q   <= reg_wdata[CGCB_B1_EN0 +: CGCB_NPAIR];
            pair_free_q <= reg_wdata[CGCB_B1_FREE0 +: CGCB_NPAIR];
        end
    end

    // readback images; bit4 is the live pin, bit6 always zero
    always_comb
    begin
        pstop_eff = pstop_bit_q & pstop_s;
        byte0 = '0;
        byte0[CGCB_B0_SEL_C:CGCB_B0_SEL_A] = freq_sel_snapshot_q;
        byte0[CGCB_B0_PSTOP]  = pstop_eff;
        byte0[CGCB_B0_HSTOP]  = hstop_s;
        byte0[CGCB_B0_VSEL]   = vsel_q;
        byte0[CGCB_B0_UNUSED] = 1'b0;
        byte0[CGCB_B0_SPREAD] = spread_q;
        byte1 = '0;
        byte1[CGCB_B1_EN0 +: CGCB_NPAIR]   = pair_en_q;
        byte1[CGCB_B1_FREE0 +: CGCB_NPAIR] = pair_free_q;
        byte1[CGCB_B1_UNUSED] = 1'b0;
        byte1[CGCB_B1_MULT]   = mult_q;
    end

    // registered read data; unmapped offsets read zero
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            reg_rdata <= '0;
        else if (reg_rd)
        begin
            if (reg_addr == CGCB_OFS_SEL_STOP)
                reg_rdata <= byte0;
            else if (reg_addr == CGCB_OFS_HOST_EN)
                reg_rdata <= byte1;
            else
                reg_rdata <= '0;
        end
    end

    // registered mode and gating outputs
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pll_enable                 <= 1'b0;
            clocks_enable              <= 1'b0;
            mode_valid                 <= 1'b0;
            freq_sel_mode              <= '0;
            multiplier_select_snapshot <= 1'b0;
            periph_clocks_run          <= 1'b0;
            video_clock_source_select  <= CGCB_RST_VSEL;
            spread_enable              <= CGCB_RST_SPREAD;
            host_pair_run              <= '0;
        end
        else
        begin
            pll_enable                 <= (state_q != CGCB_WAIT);
            clocks_enable              <= (state_q == CGCB_RUN);
            mode_valid                 <= latch_done_q;
            freq_sel_mode              <= freq_sel_snapshot_q;
            multiplier_select_snapshot <= mult_q;
            periph_clocks_run          <= (state_q == CGCB_RUN) && pstop_eff;
            video_clock_source_select  <= vsel_q;
            spread_enable              <= spread_q;
            // a pair runs if enabled and either free or stop pin not asserted
            for (int i = 0; i < CGCB_NPAIR; i++)
                host_pair_run[i] <= (state_q == CGCB_RUN) && pair_en_q[i]
                                    && (pair_free_q[i] || hstop_s);
        end
    end
endmodule : cgcb_regs
`default_nettype wire

// file: testbench/cgcb_regs_properties.sv
// port-level checker for the control byte bank
`timescale 1ns/10ps
`default_nettype none
module cgcb_regs_properties
    import cgcb_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    // pins and byte port
    input  wire logic       periph_stop_pin,
    input  wire logic       host_stop_pin,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_rdata,
    // design outputs
    input  wire logic       pll_enable,
    input  wire logic       clocks_enable,
    input  wire logic       mode_valid,
    input  wire logic [2:0] freq_sel_mode,
    input  wire logic       multiplier_select_snapshot,
    input  wire logic       video_clock_source_select,
    input  wire logic       periph_clocks_run
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic [19:0] wait_cnt_q;
    // cycles spent latched but not yet running, bounded by the stabilisation time
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n) wait_cnt_q <= 20'h0;
        else if (mode_valid && !clocks_enable) wait_cnt_q <= wait_cnt_q + 20'h1;
    end
    sequence s_rd0; reg_rd && reg_addr == CGCB_OFS_SEL_STOP; endsequence
    sequence s_rd1; reg_rd && reg_addr == CGCB_OFS_HOST_EN; endsequence
    sequence s_hstop_low; !host_stop_pin [*4] ##0 s_rd0; endsequence
    chk_sel_readback: assert property (mode_valid ##0 s_rd0 |=>
        reg_rdata[2:0] == $past(freq_sel_mode)) else $error("select readback wrong");
    chk_mult_readback: assert property (mode_valid ##0 s_rd1 |=>
        reg_rdata[CGCB_B1_MULT] == $past(multiplier_select_snapshot)) else $error("mult wrong");
    chk_live_hstop: assert property (s_hstop_low |=>
        !reg_rdata[CGCB_B0_HSTOP]) else $error("host stop readback wrong");
    // the exported select lags the stored bit by one edge, as read data does
    chk_vsel_readback: assert property (s_rd0 |=>
        reg_rdata[CGCB_B0_VSEL] == video_clock_source_select) else $error("vsel wrong");
    chk_unused_zero: assert property ((s_rd0 or s_rd1) |=>
        !reg_rdata[6]) else $error("unused bit set");
    chk_mode_held: assert property (mode_valid |=>
        mode_valid && $stable(freq_sel_mode)) else $error("mode changed");
    chk_periph_gate: assert property (!periph_stop_pin [*4] |=>
        !periph_clocks_run) else $error("peripheral clocks not stopped");
    chk_pll_after_latch: assert property ($rose(mode_valid) |-> ##[0:2] pll_enable)
        else $error("pll not enabled");
    chk_out_after_pll: assert property ($rose(clocks_enable) |-> pll_enable
        ##0 $past(pll_enable, 2)) else $error("outputs before pll");
    chk_stable_bound: assert property (wait_cnt_q <= CGCB_STABLE_CYC)
        else $error("clocks late");
endmodule : cgcb_regs_properties
bind cgcb_regs cgcb_regs_properties u_props (.clk(clk), .arst_n(arst_n),
    .periph_stop_pin(periph_stop_pin), .host_stop_pin(host_stop_pin), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_rdata(reg_rdata), .pll_enable(pll_enable),
    .clocks_enable(clocks_enable), .mode_valid(mode_valid), .freq_sel_mode(freq_sel_mode),
    .multiplier_select_snapshot(multiplier_select_snapshot),
    .video_clock_source_select(video_clock_source_select),
    .periph_clocks_run(periph_clocks_run));
`default_nettype wire

// file: testbench/cgcb_host_model.sv
// management host model issuing single byte reads and writes
`timescale 1ns/10ps
`default_nettype none
module cgcb_host_model (
    // clock
    input  wire logic       clk,
    // byte access port
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    // idle bus starts at zero and shows inverted data after a write so a stale value never looks valid
    initial
    begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge clk);
        reg_wr    = 1'b0;
        reg_wdata = ~d;
    endtask : wr
    // data is taken one cycle after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge clk);
        reg_rd   = 1'b0;
        d        = reg_rdata;
    endtask : rd
endmodule : cgcb_host_model
`default_nettype wire

// file: testbench/tb_clock_gen_control_bytes.sv
// self-checking bench for the control byte bank
`timescale 1ns/10ps
`default_nettype none
module tb_clock_gen_control_bytes;
    import cgcb_pkg::*;
    logic clk, arst_n, supply_good, mult, ps, hs, reg_wr, reg_rd, mult_snap, pll_en, clk_en;
    logic mode_valid, prun, vsel, spread;
    logic [2:0] sel, sel_mode, hrun;
    logic [7:0] addr, wdata, rdata, got, b0w, b1w, a, d, snap;
    int fails, comparisons, i, n, seed;
    cgcb_regs dut (.clk(clk), .arst_n(arst_n), .supply_good(supply_good),
        .freq_sel_pins(sel), .mult_sel_pin(mult), .periph_stop_pin(ps), .host_stop_pin(hs),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(addr), .reg_wdata(wdata),
        .reg_rdata(rdata), .pll_enable(pll_en), .clocks_enable(clk_en),
        .mode_valid(mode_valid), .freq_sel_mode(sel_mode),
        .multiplier_select_snapshot(mult_snap), .periph_clocks_run(prun),
        .video_clock_source_select(vsel), .spread_enable(spread), .host_pair_run(hrun));
    cgcb_host_model host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(addr),
        .reg_wdata(wdata), .reg_rdata(rdata));
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e)
        begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic summarize();
        if (fails == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize
    // expected bytes from written bits, latched straps and live pins
    function automatic logic [7:0] exp0(input logic [2:0] s);
        return {b0w[7], 1'b0, b0w[5], hs, b0w[3] & ps, s};
    endfunction : exp0
    task automatic step(input logic [2:0] s, input logic m);
        a = ($urandom % 3 == 0) ? 8'h02 + 8'($urandom % 254) : 8'($urandom % 2);
        d = 8'($urandom);
        host.wr(a, d);
        if (a == CGCB_OFS_SEL_STOP) b0w = d & 8'ha8;
        if (a == CGCB_OFS_HOST_EN) b1w = d & 8'h3f;
        ps = 1'($urandom);
        hs = 1'($urandom);
        repeat (3) @(negedge clk);
        host.rd(CGCB_OFS_SEL_STOP, got);
        chk(got, exp0(s));
        host.rd(CGCB_OFS_HOST_EN, got);
        chk(got, {m, 1'b0, b1w[5:0]});
        host.rd(a | 8'h02, got);
        chk(got, 8'h00);
    endtask : step
    initial
    begin
        // both sequencer delays plus room for the register scenarios
        repeat (CGCB_PLL_DLY_CYC + CGCB_OUT_DLY_CYC + 5000) @(posedge clk);
        fails++;
        summarize();
    end
    initial
    begin
        seed = $urandom(32'h3400);
        {arst_n, supply_good, ps, hs, sel, mult} = 8'($urandom) & 8'h3f;
        b0w = {CGCB_RST_SPREAD, 1'b0, CGCB_RST_VSEL, 1'b0, CGCB_RST_PSTOP, 3'h0};
        b1w = {2'h0, CGCB_RST_FREE, CGCB_RST_EN};
        repeat (6) @(negedge clk);
        arst_n = 1'b1;
        supply_good = 1'b1;
        for (n = 0; n < 50 && mode_valid !== 1'b1; n++) @(negedge clk);
        chk({7'h0, mode_valid}, 8'h01);
        // step reuses d for its own writes, so the strap snapshot lives apart
        snap = {4'h0, mult, sel};
        sel = ~sel;
        mult = ~mult;
        host.rd(CGCB_OFS_SEL_STOP, got);
        chk(got, exp0(snap[2:0]));
        host.rd(CGCB_OFS_HOST_EN, got);
        chk(got, {snap[3], 1'b0, b1w[5:0]});
        for (i = 0; i < 12; i++) step(snap[2:0], snap[3]);
        for (n = 0; n < CGCB_STABLE_CYC && clk_en !== 1'b1; n++) @(negedge clk);
        chk({6'h0, pll_en, clk_en}, 8'h03);
        for (i = 0; i < 12; i++)
        begin
            step(snap[2:0], snap[3]);
            chk({4'h0, prun, hrun}, {4'h0, b0w[3] & ps, b1w[2:0] & (b1w[5:3] | {3{hs}})});
            chk({6'h0, spread, vsel}, {6'h0, b0w[7], b0w[5]});
        end
        chk({4'h0, mult_snap, sel_mode}, snap);
        summarize();
    end
endmodule : tb_clock_gen_control_bytes
`default_nettype wire
